// ### inc/rcd_defs.svh
`ifndef RCD_DEFS_SVH
`define RCD_DEFS_SVH

// ----------------------------------------
// command word layout
// ----------------------------------------
`define RCD_WORD_W       13
`define RCD_RACK_W       6
`define RCD_CHAN_W       5
`define RCD_MODE_W       2
`define RCD_RACK_MSB     12
`define RCD_RACK_LSB     7
`define RCD_CHAN_MSB     6
`define RCD_CHAN_LSB     2
`define RCD_MODE_MSB     1
`define RCD_MODE_LSB     0

// ----------------------------------------
// mode codes
// ----------------------------------------
`define RCD_MODE_IDLE    2'h0
`define RCD_MODE_HIGH    2'h1
`define RCD_MODE_LOW     2'h2
`define RCD_MODE_NORMAL  2'h3

// ----------------------------------------
// sizes
// ----------------------------------------
`define RCD_RACK_CAP     31
`define RCD_RACKS        14
`define RCD_CHANS        20
`define RCD_SEL_CHANS    10
`define RCD_SELECTORS    2
`define RCD_IDLE_WORD    13'h0000

// ----------------------------------------
// ground controller registers
// ----------------------------------------
`define RCD_ADDR_W       8
`define RCD_REG_CMD      8'h00
`define RCD_REG_STATUS   8'h04
`define RCD_STAT_BUSY    0
`define RCD_STAT_DROP    1

// ----------------------------------------
// timing
// ----------------------------------------
`define RCD_CLK_NS       40
`define RCD_HOLD_NS      200
`define RCD_HOLD_CYC     ((`RCD_HOLD_NS + `RCD_CLK_NS - 1) / `RCD_CLK_NS)
`define RCD_CNT_W        4

`endif

// ### inc/rcd_pkg.sv
`include "rcd_defs.svh"

package rcd_pkg;

    typedef struct packed {
        logic [`RCD_RACK_W-1:0] rack;
        logic [`RCD_CHAN_W-1:0] chan;
        logic [`RCD_MODE_W-1:0] mode;
    } rcd_cmd_t;

    typedef enum logic {
        RCD_ST_IDLE,
        RCD_ST_DRIVE
    } rcd_gnd_state_t;

endpackage

// ### inc/rcd_if.sv
`timescale 1ns/1ps
`include "rcd_defs.svh"

interface rcd_if;
    logic [`RCD_WORD_W-1:0] cmd_word;

    modport ground (output cmd_word);
    modport vehicle (input cmd_word);
endinterface

// ### src/rcd_vehicle.sv
`timescale 1ns/1ps
`include "rcd_defs.svh"

module rcd_vehicle (
    // clock and power reset
    input  wire logic                                ref_clk,
    input  wire logic                                sys_rst,
    // umbilical command word
    rcd_if.vehicle                                   link,
    // relay drives, index (rack-1)*20 + channel-1
    output logic [`RCD_RACKS*`RCD_CHANS-1:0]         relay_high,
    output logic [`RCD_RACKS*`RCD_CHANS-1:0]         relay_low,
    // sensor path per channel
    output logic [`RCD_RACKS*`RCD_CHANS-1:0]         sensor_connect,
    // rack status
    output logic [`RCD_RACKS-1:0]                    rack_in_checkout,
    output logic                                     any_checkout
);

    // ----------------------------------------
    // incoming word split
    // ----------------------------------------
    rcd_pkg::rcd_cmd_t                 in_cmd;
    logic                              in_rack_ok;
    logic                              in_chan_ok;
    logic                              in_mode_act;

    assign in_cmd      = rcd_pkg::rcd_cmd_t'(link.cmd_word);
    // rack code is 6 bits wide, only racks 1..14 accepted by the check
    assign in_rack_ok  = (in_cmd.rack != 6'h00) &&
                         (in_cmd.rack <= 6'(`RCD_RACK_CAP)) &&
                         (in_cmd.rack <= 6'(`RCD_RACKS));
    assign in_chan_ok  = (in_cmd.chan != 5'h00) &&
                         (in_cmd.chan <= 5'(`RCD_CHANS));
    assign in_mode_act = (in_cmd.mode != `RCD_MODE_IDLE);

    // ----------------------------------------
    // rack selector stage
    // ----------------------------------------
    logic [`RCD_RACKS-1:0]             rack_sel;
    logic [`RCD_RACKS-1:0]             next_rack_sel;
    logic [`RCD_CHAN_W-1:0]            chan_buf;
    logic [`RCD_MODE_W-1:0]            mode_buf;
    logic [`RCD_MODE_W-1:0]            next_mode_buf;
    logic                              word_valid;

    // bad channel drops the whole command before distribution
    assign word_valid    = in_rack_ok && in_chan_ok && in_mode_act;
    assign next_mode_buf = word_valid ? in_cmd.mode : `RCD_MODE_IDLE;

    genvar gr;
    generate
        for (gr = 0; gr < `RCD_RACKS; gr++) begin : g_rack_dec
            // one-hot select toward the addressed rack only
            assign next_rack_sel[gr] = word_valid &&
                                       (in_cmd.rack == 6'(gr + 1));
        end
    endgenerate

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rack_sel <= '0;
            chan_buf <= 5'h00;
            mode_buf <= `RCD_MODE_IDLE;
        end else begin
            rack_sel <= next_rack_sel;
            chan_buf <= in_cmd.chan;
            mode_buf <= next_mode_buf;
        end
    end

    // ----------------------------------------
    // common channel and mode lines
    // ----------------------------------------
    logic [`RCD_CHANS-1:0]             chan_sel;
    logic                              mode_high;
    logic                              mode_low;
    logic                              mode_normal;

    genvar gc;
    generate
        for (gc = 0; gc < `RCD_CHANS; gc++) begin : g_chan_dec
            // shared by every rack
            assign chan_sel[gc] = (chan_buf == 5'(gc + 1));
        end
    endgenerate

    assign mode_high   = (mode_buf == `RCD_MODE_HIGH);
    assign mode_low    = (mode_buf == `RCD_MODE_LOW);
    assign mode_normal = (mode_buf == `RCD_MODE_NORMAL);

    // ----------------------------------------
    // channel selector halves
    // ----------------------------------------
    logic [`RCD_SELECTORS-1:0]         half_sel;

    genvar gh;
    generate
        for (gh = 0; gh < `RCD_SELECTORS; gh++) begin : g_half
            // first selector takes channels 1-10, second 11-20
            // channel 0 or above 20 wakes neither half
            assign half_sel[gh] = |chan_sel[gh*`RCD_SEL_CHANS +: `RCD_SEL_CHANS];
        end
    endgenerate

    // ----------------------------------------
    // channel selectors and relay latches
    // ----------------------------------------
    logic [`RCD_RACKS*`RCD_CHANS-1:0]  gate_high;
    logic [`RCD_RACKS*`RCD_CHANS-1:0]  gate_low;
    logic [`RCD_RACKS*`RCD_CHANS-1:0]  gate_normal;
    logic [`RCD_RACKS*`RCD_CHANS-1:0]  next_latch_high;
    logic [`RCD_RACKS*`RCD_CHANS-1:0]  next_latch_low;
    logic [`RCD_RACKS*`RCD_CHANS-1:0]  latch_high;
    logic [`RCD_RACKS*`RCD_CHANS-1:0]  latch_low;

    genvar rk;
    genvar sl;
    genvar ch;
    generate
        for (rk = 0; rk < `RCD_RACKS; rk++) begin : g_rack
            // two selectors per rack, ten channels each
            for (sl = 0; sl < `RCD_SELECTORS; sl++) begin : g_sel
                logic sel_act;

                // selector wakes only for its rack and its half
                assign sel_act = rack_sel[rk] && half_sel[sl];

                for (ch = 0; ch < `RCD_SEL_CHANS; ch++) begin : g_ch
                    localparam int CIDX = sl * `RCD_SEL_CHANS + ch;
                    localparam int RIDX = rk * `RCD_CHANS + CIDX;

                    logic hold_high;
                    logic hold_low;
                    logic keep_high;
                    logic keep_low;

                    // ten channels, three gates each (high, low, normal): thirty per selector
                    assign gate_high[RIDX]   = sel_act && chan_sel[CIDX] &&
                                               mode_high;
                    assign gate_low[RIDX]    = sel_act && chan_sel[CIDX] &&
                                               mode_low;
                    assign gate_normal[RIDX] = sel_act && chan_sel[CIDX] &&
                                               mode_normal;

                    // any other mode for this channel drops the relay
                    assign keep_high = hold_high && !gate_low[RIDX] && !gate_normal[RIDX];
                    assign keep_low  = hold_low && !gate_high[RIDX] && !gate_normal[RIDX];
                    assign next_latch_high[RIDX] = gate_high[RIDX] || keep_high;
                    assign next_latch_low[RIDX]  = gate_low[RIDX] || keep_low;

                    // latch holds between commands; power loss clears
                    always_ff @(posedge ref_clk or posedge sys_rst) begin
                        if (sys_rst) begin
                            hold_high <= 1'b0;
                            hold_low  <= 1'b0;
                        end else begin
                            // other channels keep their state
                            hold_high <= next_latch_high[RIDX];
                            hold_low  <= next_latch_low[RIDX];
                        end
                    end

                    assign latch_high[RIDX] = hold_high;
                    assign latch_low[RIDX]  = hold_low;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // relay outputs
    // ----------------------------------------
    assign relay_high = latch_high;
    assign relay_low  = latch_low;

    // ----------------------------------------
    // rack checkout summary for telemetry
    // ----------------------------------------
    logic [`RCD_RACKS-1:0]             next_rack_busy;

    genvar gs;
    generate
        for (gs = 0; gs < `RCD_RACKS; gs++) begin : g_sum
            assign next_rack_busy[gs] =
                |(next_latch_high[gs*`RCD_CHANS +: `RCD_CHANS] |
                  next_latch_low[gs*`RCD_CHANS +: `RCD_CHANS]);
        end
    endgenerate

    // ----------------------------------------
    // registered sensor and status outputs
    // ----------------------------------------
    // taken from next state so they line up with the relays
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sensor_connect   <= '1;
            rack_in_checkout <= '0;
            any_checkout     <= 1'b0;
        end else begin
            // sensor wired in only while both relays are off
            sensor_connect   <= ~(next_latch_high | next_latch_low);
            rack_in_checkout <= next_rack_busy;
            // telemetry only; nothing goes back to the ground side
            any_checkout     <= |next_rack_busy;
        end
    end

endmodule

// ### src/rcd_ground.sv
`timescale 1ns/1ps
`include "rcd_defs.svh"

module rcd_ground (
    // clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     sys_rst,
    // register port
    input  wire logic [`RCD_ADDR_W-1:0]   reg_addr,
    input  wire logic [31:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic [31:0]                   reg_rdata,
    // umbilical
    rcd_if.ground                         link
);

    // ----------------------------------------
    // decode
    // ----------------------------------------
    rcd_pkg::rcd_gnd_state_t   state;
    rcd_pkg::rcd_gnd_state_t   next_state;
    logic [`RCD_WORD_W-1:0]    last_word;
    logic [`RCD_CNT_W-1:0]     hold_cnt;
    logic                      drop_flag;
    logic                      hit_cmd;
    logic                      hit_stat;
    logic                      cmd_take;
    logic                      cmd_drop;
    logic                      drop_clr;
    logic                      hold_done;
    logic [31:0]               next_rdata;

    assign hit_cmd   = (reg_addr == `RCD_REG_CMD);
    assign hit_stat  = (reg_addr == `RCD_REG_STATUS);
    assign cmd_take  = reg_wr && hit_cmd && (state == rcd_pkg::RCD_ST_IDLE);
    assign cmd_drop  = reg_wr && hit_cmd && (state == rcd_pkg::RCD_ST_DRIVE);
    assign drop_clr  = reg_wr && hit_stat && reg_wdata[`RCD_STAT_DROP];
    assign hold_done = (hold_cnt == `RCD_CNT_W'(`RCD_HOLD_CYC - 1));
    assign next_rdata = (reg_rd && hit_cmd)  ? {19'h00000, last_word} :
                        (reg_rd && hit_stat) ? {30'h00000000, drop_flag,
                                                state == rcd_pkg::RCD_ST_DRIVE} :
                        32'h00000000;

    always_comb begin
        next_state = state;
        unique case (state)
            rcd_pkg::RCD_ST_IDLE:  if (cmd_take) next_state = rcd_pkg::RCD_ST_DRIVE;
            rcd_pkg::RCD_ST_DRIVE: if (hold_done) next_state = rcd_pkg::RCD_ST_IDLE;
        endcase
    end

    // ----------------------------------------
    // word driver
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state         <= rcd_pkg::RCD_ST_IDLE;
            link.cmd_word <= `RCD_IDLE_WORD;
            last_word     <= `RCD_IDLE_WORD;
            hold_cnt      <= '0;
        end else begin
            state <= next_state;
            if (cmd_take) begin
                link.cmd_word <= reg_wdata[`RCD_WORD_W-1:0];
                last_word     <= reg_wdata[`RCD_WORD_W-1:0];
                hold_cnt      <= '0;
            end else if (state == rcd_pkg::RCD_ST_DRIVE) begin
                hold_cnt <= hold_cnt + `RCD_CNT_W'(1);
                if (hold_done) begin
                    link.cmd_word <= `RCD_IDLE_WORD;
                end
            end
        end
    end

    // ----------------------------------------
    // status and read port
    // ----------------------------------------
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            drop_flag <= 1'b0;
            reg_rdata <= 32'h00000000;
        end else begin
            // set wins over clear
            drop_flag <= cmd_drop | (drop_flag & ~drop_clr);
            reg_rdata <= next_rdata;
        end
    end

endmodule

// ### sim/rcd_monitor.sv
`timescale 1ns/1ps
`include "rcd_defs.svh"

module rcd_monitor (
    // clock and reset
    input  wire logic                                ref_clk,
    input  wire logic                                sys_rst,
    // register port and link
    input  wire logic [`RCD_ADDR_W-1:0]              reg_addr,
    input  wire logic [31:0]                         reg_wdata,
    input  wire logic                                reg_wr,
    input  wire logic [`RCD_WORD_W-1:0]              cmd_word,
    // vehicle outputs
    input  wire logic [`RCD_RACKS*`RCD_CHANS-1:0]    relay_high,
    input  wire logic [`RCD_RACKS*`RCD_CHANS-1:0]    relay_low,
    input  wire logic [`RCD_RACKS*`RCD_CHANS-1:0]    sensor_connect
);
    // ----------------------------------------
    // command decode
    // ----------------------------------------
    wire logic [5:0]  rack     = cmd_word[`RCD_RACK_MSB:`RCD_RACK_LSB];
    wire logic [4:0]  chan     = cmd_word[`RCD_CHAN_MSB:`RCD_CHAN_LSB];
    wire logic [1:0]  mode     = cmd_word[`RCD_MODE_MSB:`RCD_MODE_LSB];
    wire logic        valid    = rack != 6'h00 && rack <= 6'h0E && chan != 5'h00 && chan <= 5'h14 && mode != 2'h0;
    wire logic        inval    = !valid;
    wire logic        hit_hi   = valid && mode == `RCD_MODE_HIGH;
    wire logic        hit_lo   = valid && mode == `RCD_MODE_LOW;
    wire logic        hit_nm   = valid && mode == `RCD_MODE_NORMAL;
    wire logic [8:0]  idx      = ({3'h0, rack} - 9'h001) * 9'h014 + {4'h0, chan} - 9'h001;
    wire logic [12:0] wr_word  = reg_wdata[12:0];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    chk_sensor_path: assert property (sensor_connect == ~(relay_high | relay_low))
        else $error("sensor path differs from relay state");
    chk_relay_exclusive: assert property ((relay_high & relay_low) == '0)
        else $error("high and low relay energized together");
    chk_power_normal: assert property ($fell(sys_rst) |-> relay_high == '0 && relay_low == '0 && cmd_word == '0)
        else $error("relays not normal after power loss");
    chk_latch_hold: assert property ($past(inval) && $past(inval, 2) && $past(inval, 3)
        |-> $stable(relay_high) && $stable(relay_low))
        else $error("relays changed without a valid command");
    chk_high_latch: assert property ($past(hit_hi, 3) |-> relay_high[$past(idx, 3)] && !relay_low[$past(idx, 3)])
        else $error("high relay not latched");
    chk_low_latch: assert property ($past(hit_lo, 3) |-> relay_low[$past(idx, 3)] && !relay_high[$past(idx, 3)])
        else $error("low relay not latched");
    chk_normal_release: assert property ($past(hit_nm, 3) |-> !relay_low[$past(idx, 3)] && !relay_high[$past(idx, 3)])
        else $error("channel not released to normal");
    chk_word_hold: assert property (cmd_word != '0 && $past(cmd_word) == '0
        |-> ##1 $stable(cmd_word) [*4] ##1 cmd_word == '0)
        else $error("command word not held for five cycles");
    chk_word_source: assert property (reg_wr && reg_addr == `RCD_REG_CMD && cmd_word == '0
        |=> cmd_word == $past(wr_word))
        else $error("command word differs from written value");
endmodule

// ### sim/tb_remote_calibration_decoder.sv
`timescale 1ns/1ps
`include "rcd_defs.svh"

module tb_remote_calibration_decoder;
    localparam int NB = `RCD_RACKS * `RCD_CHANS;
    localparam logic [12:0] DIR [13] = '{{6'h01, 5'h01, 2'h1}, {6'h0E, 5'h14, 2'h2}, {6'h0E, 5'h0A, 2'h1},
        {6'h0E, 5'h0B, 2'h2}, {6'h01, 5'h01, 2'h2}, {6'h0E, 5'h14, 2'h3}, {6'h0E, 5'h0A, 2'h0},
        {6'h00, 5'h05, 2'h1}, {6'h0F, 5'h05, 2'h1}, {6'h3F, 5'h05, 2'h1}, {6'h03, 5'h00, 2'h1},
        {6'h03, 5'h15, 2'h1}, {6'h03, 5'h1F, 2'h2}};
    localparam logic [12:0] W1 = {6'h05, 5'h07, 2'h1};
    localparam logic [12:0] W2 = {6'h05, 5'h08, 2'h2};

    logic                     ref_clk   = 1'b0;
    logic                     sys_rst   = 1'b1;
    logic [`RCD_ADDR_W-1:0]   reg_addr  = 8'h00;
    logic [31:0]              reg_wdata = 32'h0000_0000;
    logic                     reg_wr    = 1'b0;
    logic                     reg_rd    = 1'b0;
    logic [31:0]              reg_rdata;
    logic [NB-1:0]            relay_high, relay_low, sensor_connect;
    logic [NB-1:0]            exp_hi    = '0;
    logic [NB-1:0]            exp_lo    = '0;
    logic [`RCD_RACKS-1:0]    rack_in_checkout;
    logic                     any_checkout;
    logic [31:0]              seed      = 32'h0000_9E0B;
    logic [31:0]              r;
    int                       failures  = 0;
    int                       n_compared = 0;

    rcd_if link_if ();
    rcd_ground rcd_ground_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link(link_if));
    rcd_vehicle rcd_vehicle_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link_if), .relay_high(relay_high),
        .relay_low(relay_low), .sensor_connect(sensor_connect), .rack_in_checkout(rack_in_checkout),
        .any_checkout(any_checkout));
    rcd_monitor rcd_monitor_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .cmd_word(link_if.cmd_word), .relay_high(relay_high), .relay_low(relay_low),
        .sensor_connect(sensor_connect));

    initial forever #20 ref_clk = ~ref_clk;

    // ----------------------------------------
    // expectation helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [`RCD_RACKS-1:0] racks_of(input logic [NB-1:0] v);
        logic [`RCD_RACKS-1:0] f;
        for (int k = 0; k < `RCD_RACKS; k++) f[k] = |v[k*`RCD_CHANS +: `RCD_CHANS];
        return f;
    endfunction

    task automatic apply(input logic [12:0] w);
        int i;
        i = (int'(w[12:7]) - 1) * `RCD_CHANS + int'(w[6:2]) - 1;
        if (w[12:7] != 6'h00 && w[12:7] <= 6'h0E && w[6:2] != 5'h00 && w[6:2] <= 5'h14 && w[1:0] != 2'h0) begin
            exp_hi[i] = (w[1:0] == `RCD_MODE_HIGH);
            exp_lo[i] = (w[1:0] == `RCD_MODE_LOW);
        end
    endtask

    // ----------------------------------------
    // compare and bus tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [NB-1:0] e, input logic [NB-1:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic check_all();
        chk("relay_high", exp_hi, relay_high);
        chk("relay_low", exp_lo, relay_low);
        chk("sensor_connect", ~(exp_hi | exp_lo), sensor_connect);
        chk("rack_in_checkout", NB'(racks_of(exp_hi | exp_lo)), NB'(rack_in_checkout));
        chk("any_checkout", NB'((exp_hi | exp_lo) != '0), NB'(any_checkout));
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= a;
        reg_wdata <= d;
    endtask

    task automatic idle();
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", NB'(e), NB'(reg_rdata));
    endtask

    task automatic send(input logic [12:0] w);
        wr_reg(`RCD_REG_CMD, {19'h0, w});
        idle();
        repeat (7) @(posedge ref_clk);
        #1 apply(w);
        check_all();
    endtask

    task automatic summarize();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        #1 check_all();
        foreach (DIR[i]) send(DIR[i]);
        $display("test directed done");
        wr_reg(`RCD_REG_CMD, {19'h0, W1});
        wr_reg(`RCD_REG_CMD, {19'h0, W2});
        rd_reg(`RCD_REG_STATUS, 32'h0000_0003);
        rd_reg(`RCD_REG_CMD, {19'h0, W1});
        wr_reg(8'h08, {19'h0, W2});
        rd_reg(8'h08, 32'h0000_0000);
        repeat (7) @(posedge ref_clk);
        #1 apply(W1);
        check_all();
        wr_reg(`RCD_REG_STATUS, 32'h0000_0002);
        rd_reg(`RCD_REG_STATUS, 32'h0000_0000);
        $display("test refusal done");
        repeat (80) begin
            r = rnd();
            send({{2'h0, r[3:0]} + 6'h01, r[8:4], r[10:9]});
        end
        $display("test random done");
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        exp_hi = '0;
        exp_lo = '0;
        @(posedge ref_clk);
        #1 check_all();
        send(DIR[1]);
        $display("test power loss done");
        summarize();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        $display("[FAIL] watchdog expected finish seen hang");
        summarize();
    end
endmodule
